// ### design/udrt_defs.svh
`ifndef UDRT_DEFS_SVH
`define UDRT_DEFS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define UDRT_ADDR_W 4
`define UDRT_ADDR_MODE 4'h0
`define UDRT_ADDR_COUNT 4'h1
`define UDRT_ADDR_LOAD 4'h2

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define UDRT_BIT_RELOAD 7
`define UDRT_BIT_DIR_SRC 6
`define UDRT_BIT_DIR_FIX 5
`define UDRT_CKS_HI 2
`define UDRT_CKS_LO 0
`define UDRT_MODE_WMASK 8'hE7
`define UDRT_MODE_RSVD 8'h18
`define UDRT_MODE_RESET 8'h18
`define UDRT_COUNT_RESET 8'h00
`define UDRT_LOAD_RESET 8'h00

// ----------------------------------------
// Prescaler
// ----------------------------------------
`define UDRT_PRE_W 13
`define UDRT_SUB_DIV_W 2

`endif

// ### design/udrt_pkg.sv
package udrt_pkg;
	// Count source selection codes
	typedef enum logic [2:0] {
		udrt_cks_div8192,
		udrt_cks_div2048,
		udrt_cks_div512,
		udrt_cks_div64,
		udrt_cks_div16,
		udrt_cks_div4,
		udrt_cks_sub4,
		udrt_cks_event
	} udrt_cks_e;
endpackage

// ### design/udrt_prescaler.sv
`timescale 1ns/1ns
`include "udrt_defs.svh"

module udrt_prescaler (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Subclock tick from elsewhere in the chip
	input wire logic sub_tick,
	// Divided ticks, one-cycle pulses
	output logic tick_8192,
	output logic tick_2048,
	output logic tick_512,
	output logic tick_64,
	output logic tick_16,
	output logic tick_4,
	output logic tick_sub4
);

	logic [`UDRT_PRE_W-1:0] pre;
	logic [`UDRT_PRE_W-1:0] next_pre;
	logic [`UDRT_SUB_DIV_W-1:0] sub;
	logic [`UDRT_SUB_DIV_W-1:0] next_sub;

	// ----------------------------------------
	// Free-running dividers
	// ----------------------------------------
	// Next values of both dividers
	always_comb begin
		next_pre = pre + 13'h0001;
		next_sub = sub;
		if (sub_tick) begin
			next_sub = sub + 2'h1;
		end
	end

	// Register the dividers
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pre <= 13'h0000;
			sub <= 2'h0;
		end else begin
			pre <= next_pre;
			sub <= next_sub;
		end
	end

	// Each tick fires when the low bits wrap; shared counter keeps phases
	// aligned, at the cost of a fixed phase after a mode change
	assign tick_8192 = (pre == 13'h1FFF);
	assign tick_2048 = (pre[10:0] == 11'h7FF);
	assign tick_512 = (pre[8:0] == 9'h1FF);
	assign tick_64 = (pre[5:0] == 6'h3F);
	assign tick_16 = (pre[3:0] == 4'hF);
	assign tick_4 = (pre[1:0] == 2'h3);
	assign tick_sub4 = sub_tick && (sub == 2'h3);

endmodule

// ### design/udrt_edge_detect.sv
`timescale 1ns/1ns

module udrt_edge_detect (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Sampled event pin
	input wire logic level_in,
	// Pulse on either edge
	output logic edge_pulse
);

	logic last;
	logic next_last;

	// Track the previous level
	always_comb begin
		next_last = level_in;
	end

	// Register the previous level
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			last <= 1'b0;
		end else begin
			last <= next_last;
		end
	end

	// Both edges count; a pin held high through reset gives one event
	assign edge_pulse = level_in ^ last;

endmodule

// ### design/udrt_timer.sv
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "udrt_defs.svh"

// Overview of operation
// R1: Direction bits both zero: counter increments on each selected event.
// R2: Upper direction bit zero, lower one: counter decrements per event.
// R3: Upper direction bit one: direction comes from the direction pin.
// R4: Under pin control, pin high counts down, pin low counts up.
// R5: Mode bit 7 zero selects interval timer, one selects auto-reload.
// R6: Three-bit clock select picks prescaled clock, subclock/4 or pin edges.
// R7: Count is 8-bit read-only, resets to zero, writes ignored.
// R8: Interval mode wraps modulo 256; auto-reload reloads load value on wrap.
module udrt_timer (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [`UDRT_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// External pins and subclock
	input wire logic third_timer_event_input,
	input wire logic count_direction_pin,
	input wire logic sub_tick,
	// Status
	output logic [7:0] third_timer_count,
	output logic wrap_pulse
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [7:0] third_timer_mode_register;
	logic [7:0] next_mode;
	logic [7:0] load_value;
	logic [7:0] next_load;
	logic [7:0] next_count;
	logic [7:0] next_rdata;
	logic tick_8192;
	logic tick_2048;
	logic tick_512;
	logic tick_64;
	logic tick_16;
	logic tick_4;
	logic tick_sub4;
	logic event_edge;
	logic count_event;
	logic count_down;
	logic reload_function_select;
	logic direction_source_select;
	logic direction_fixed_select;
	udrt_pkg::udrt_cks_e clock_sel;

	// ----------------------------------------
	// Count sources
	// ----------------------------------------
	udrt_prescaler u_pre (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.sub_tick(sub_tick),
		.tick_8192(tick_8192),
		.tick_2048(tick_2048),
		.tick_512(tick_512),
		.tick_64(tick_64),
		.tick_16(tick_16),
		.tick_4(tick_4),
		.tick_sub4(tick_sub4)
	);

	udrt_edge_detect u_edge (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.level_in(third_timer_event_input),
		.edge_pulse(event_edge)
	);

	// Mode field decode
	assign reload_function_select =
		third_timer_mode_register[`UDRT_BIT_RELOAD];
	assign direction_source_select =
		third_timer_mode_register[`UDRT_BIT_DIR_SRC];
	assign direction_fixed_select =
		third_timer_mode_register[`UDRT_BIT_DIR_FIX];
	assign clock_sel = udrt_pkg::udrt_cks_e'(
		third_timer_mode_register[`UDRT_CKS_HI:`UDRT_CKS_LO]);

	// Pick one tick source from the clock select field
	always_comb begin
		count_event = 1'b0;
		unique case (clock_sel)
			udrt_pkg::udrt_cks_div8192: count_event = tick_8192; // [R6]
			udrt_pkg::udrt_cks_div2048: count_event = tick_2048; // [R6]
			udrt_pkg::udrt_cks_div512: count_event = tick_512; // [R6]
			udrt_pkg::udrt_cks_div64: count_event = tick_64; // [R6]
			udrt_pkg::udrt_cks_div16: count_event = tick_16; // [R6]
			udrt_pkg::udrt_cks_div4: count_event = tick_4; // [R6]
			udrt_pkg::udrt_cks_sub4: count_event = tick_sub4; // [R6]
			udrt_pkg::udrt_cks_event: count_event = event_edge; // [R6]
		endcase
	end

	// Direction: pin wins when the source bit is set
	always_comb begin
		if (direction_source_select) begin
			count_down = count_direction_pin; // [R3] [R4]
		end else begin
			count_down = direction_fixed_select; // [R1] [R2]
		end
	end

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	// Next count and wrap detection
	always_comb begin
		next_count = third_timer_count;
		wrap_pulse = 1'b0;
		if (count_event) begin
			if (count_down) begin
				wrap_pulse = (third_timer_count == 8'h00);
				next_count = third_timer_count - 8'h01; // [R2]
			end else begin
				wrap_pulse = (third_timer_count == 8'hFF);
				next_count = third_timer_count + 8'h01; // [R1]
			end
			// Reload restarts the count from the load value in either
			// direction; interval mode just lets the sum wrap
			if (wrap_pulse && reload_function_select) begin
				next_count = load_value; // [R5] [R8]
			end
		end
	end

	// Count has no write path from the bus
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			third_timer_count <= `UDRT_COUNT_RESET; // [R7]
		end else begin
			third_timer_count <= next_count; // [R8]
		end
	end

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	// Writes to mode and load; count writes dropped
	always_comb begin
		next_mode = third_timer_mode_register;
		next_load = load_value;
		next_rdata = 8'h00;
		if (reg_wr && reg_addr == `UDRT_ADDR_MODE) begin
			next_mode = (reg_wdata & `UDRT_MODE_WMASK) | `UDRT_MODE_RSVD;
		end
		if (reg_wr && reg_addr == `UDRT_ADDR_LOAD) begin
			next_load = reg_wdata;
		end
		// Load is write-only, so it reads as zero like unmapped space
		if (reg_rd) begin
			unique case (reg_addr)
				`UDRT_ADDR_MODE: next_rdata = third_timer_mode_register;
				`UDRT_ADDR_COUNT: next_rdata = third_timer_count; // [R7]
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// Register file and read data
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			third_timer_mode_register <= `UDRT_MODE_RESET;
			load_value <= `UDRT_LOAD_RESET;
			reg_rdata <= 8'h00;
		end else begin
			third_timer_mode_register <= next_mode;
			load_value <= next_load;
			reg_rdata <= next_rdata;
		end
	end

endmodule

// ### verification/udrt_chk.sv
`timescale 1ns/1ns
module udrt_chk (
	// Clock and reset
	input logic ref_clk,
	input logic rst_b,
	// Register port
	input logic [3:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	input logic [7:0] reg_rdata,
	// Pins and status
	input logic third_timer_event_input,
	input logic count_direction_pin,
	input logic [7:0] third_timer_count,
	input logic wrap_pulse
);
	logic [7:0] m, l, pc, pm;
	logic pr, pd;
	wire [7:0] c = third_timer_count;
	// A count move outside reset and outside reload mode
	wire mv = pr && c != pc && !pm[7];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Bus view of mode and load; copies from the cycle before
	always_ff @(posedge ref_clk) begin
		pc <= c;
		pm <= m;
		pr <= rst_b;
		pd <= count_direction_pin;
		if (!rst_b) begin
			m <= 8'h18;
			l <= 8'h00;
		end else if (reg_wr && reg_addr == 4'h0) begin
			m <= reg_wdata | 8'h18;
		end else if (reg_wr && reg_addr == 4'h2) begin
			l <= reg_wdata;
		end
	end
	// Reset has its own check, so the default disable is lifted here
	rst_zero_a: assert property (disable iff (1'b0)
		!rst_b |=> c == 8'h00) else $error("count not cleared");
	up_step_a: assert property (
		mv && pm[6:5] == 2'b00 |-> c == pc + 8'h01) else $error("bad up step");
	down_step_a: assert property (
		mv && pm[6:5] == 2'b01 |-> c == pc - 8'h01) else $error("bad down step");
	pin_dir_a: assert property (
		mv && pm[6] |-> c == (pd ? pc - 8'h01 : pc + 8'h01))
		else $error("pin direction ignored");
	count_read_a: assert property (
		reg_rd && reg_addr == 4'h1 |=> reg_rdata == $past(c))
		else $error("count read wrong");
	mode_read_a: assert property (
		reg_rd && reg_addr == 4'h0 |=> reg_rdata == $past(m))
		else $error("mode read wrong");
	reload_a: assert property (
		m[7] && wrap_pulse |=> c == $past(l)) else $error("no reload");
	wrap_flag_a: assert property (
		mv && (pc == 8'hFF && c == 8'h00 || pc == 8'h00 && c == 8'hFF)
		|-> $past(wrap_pulse)) else $error("wrap pulse missing");
	event_quiet_a: assert property (
		(m[2:0] == 3'h7 && $stable(third_timer_event_input) && $stable(m))[*8]
		|-> $stable(c)) else $error("count moved without event");
	// Main scenarios reached
	cover property (m[7] && wrap_pulse);
	cover property (mv && pm[6] && pd);
	cover property (reg_rd && reg_addr == 4'h1);
endmodule

bind udrt_timer udrt_chk chk (.ref_clk(ref_clk), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.third_timer_event_input(third_timer_event_input),
	.count_direction_pin(count_direction_pin),
	.third_timer_count(third_timer_count), .wrap_pulse(wrap_pulse));

// ### verification/udrt_pins.sv
`timescale 1ns/1ns
module udrt_pins (
	// Clock and reset
	input logic ref_clk,
	input logic rst_b,
	// Requests from the bench
	input logic ev_go,
	input logic dir_want,
	// Pins
	output logic ev,
	output logic dir
);
	// Each request flips the event line; both edges are events
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ev <= 1'b0;
		end else if (ev_go) begin
			ev <= ~ev;
		end
		dir <= dir_want;
	end
endmodule

// ### verification/test_updown_reload_timer.sv
`timescale 1ns/1ns
module test_updown_reload_timer;
	logic ref_clk = 1'b0, rst_b = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
	logic sub = 1'b0, go = 1'b0, dw = 1'b0, rd_seen = 1'b0;
	logic wrap_seen = 1'b0, wrp;
	logic [3:0] a = 4'h0;
	logic [7:0] wd = 8'h00, rdata, e, ld, m, cnt;
	logic ev, dir;
	logic [7:0] note_q[$];
	logic [7:0] wrap_q[$];
	logic [7:0] md[6] = '{8'h1F, 8'h3F, 8'h5F, 8'h9F, 8'hBF, 8'hDF};
	int dv[7] = '{8192, 2048, 512, 64, 16, 4, 32};
	int mismatches = 0, compares = 0, seed = 81355, w;
	// 25 MHz clock
	always #20 ref_clk = ~ref_clk;
	udrt_timer dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(a),
		.reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata),
		.third_timer_event_input(ev), .count_direction_pin(dir),
		.sub_tick(sub), .third_timer_count(cnt), .wrap_pulse(wrp));
	udrt_pins pins (.ref_clk(ref_clk), .rst_b(rst_b), .ev_go(go),
		.dir_want(dw), .ev(ev), .dir(dir));
	task automatic wr(input logic [3:0] ad, input logic [7:0] d);
		@(posedge ref_clk);
		wr_s <= 1'b1;
		a <= ad;
		wd <= d;
		@(posedge ref_clk);
		wr_s <= 1'b0;
	endtask
	// Read notes its expected data for the monitor
	task automatic rd(input logic [3:0] ad, input logic [7:0] x);
		@(posedge ref_clk);
		rd_s <= 1'b1;
		a <= ad;
		note_q.push_back(x);
		@(posedge ref_clk);
		rd_s <= 1'b0;
	endtask
	// Expected count after one event; a wrap also notes its new count
	task automatic step(input logic d);
		if (m[6] ? d : m[5]) begin
			if (e == 8'h00) begin
				e = m[7] ? ld : 8'hFF;
				wrap_q.push_back(e);
			end else begin
				e = e - 8'h01;
			end
		end else begin
			if (e == 8'hFF) begin
				e = m[7] ? ld : 8'h00;
				wrap_q.push_back(e);
			end else begin
				e = e + 8'h01;
			end
		end
	endtask
	// Direction settles well before and after the event edge; the
	// expectation is noted first so the monitor finds it at the wrap
	task automatic tick(input logic d);
		dw <= d;
		repeat (4) @(posedge ref_clk);
		step(d);
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		repeat (5) @(posedge ref_clk);
	endtask
	task automatic wrap_up;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Read data stands only in the cycle after the strobe
	always @(posedge ref_clk) begin
		if (rd_seen) begin
			compares++;
			if (rdata !== note_q.pop_front()) begin
				mismatches++;
				$display("[FAIL] %0t read data mismatch", $time);
			end
		end
		rd_seen = rd_s;
		// A wrap shows its new count in the following cycle
		if (wrap_seen) begin
			compares++;
			if (cnt !== wrap_q.pop_front()) begin
				mismatches++;
				$display("[FAIL] %0t count after wrap wrong", $time);
			end
		end
		wrap_seen = wrp;
	end
	// Watchdog, well past the expected run length
	initial begin
		#3000000;
		mismatches++;
		wrap_up();
	end
	// Main sequence
	initial begin
		e = 8'h00;
		m = 8'h1F;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(4'h0, 8'h18);
		rd(4'h2, 8'h00);
		rd(4'hF, 8'h00);
		wr(4'h1, 8'($random(seed)));
		rd(4'h1, 8'h00);
		// Each source runs a whole number of its periods
		for (int k = 0; k < 7; k++) begin
			w = dv[k] > 64 ? dv[k] : 64;
			wr(4'h0, 8'(k));
			for (int i = 0; i < w - 2; i++) begin
				sub <= k == 6 && i < 16 && i % 2 == 0;
				@(posedge ref_clk);
			end
			wr(4'h0, 8'h07);
			repeat (w / dv[k]) step(1'b0);
			rd(4'h1, e);
		end
		ld = {4'hF, 4'($random(seed))};
		wr(4'h2, ld);
		// Enough events to wrap in every fixed direction
		foreach (md[j]) begin
			m = md[j];
			wr(4'h0, m);
			rd(4'h0, m);
			repeat (260 + j) tick(m[6] & 1'($random(seed)));
			rd(4'h1, e);
		end
		// Every expected wrap must have been seen by now
		compares++;
		if (wrap_q.size() != 0) begin
			mismatches++;
			$display("[FAIL] %0t missing wrap pulse", $time);
		end
		wrap_up();
	end
endmodule
